// File: hw/scs_map.vh
`ifndef SCS_MAP_VH
`define SCS_MAP_VH

// ****************************************
// Word and counter widths
// ****************************************
`define SCS_WORD_W        8
`define SCS_DIV_W         8
`define SCS_CNT_W         9
`define SCS_NBIT_W        4
`define SCS_BITS_PER_WORD 4'h8
`define SCS_CNT_ONE       9'h001
`define SCS_DIV_MIN       8'h01
`define SCS_FIFO_DEPTH    4
`define SCS_FIFO_AW       2

// ****************************************
// Clock stop modes
// ****************************************
`define SCS_MODE_NODLY    2'h2
`define SCS_MODE_DLY      2'h3

// ****************************************
// Master sequencer states
// ****************************************
`define SCS_ST_IDLE       5'h01
`define SCS_ST_LEAD       5'h02
`define SCS_ST_ACT        5'h04
`define SCS_ST_INACT      5'h08
`define SCS_ST_TRAIL      5'h10

// ****************************************
// Synchroniser lanes
// ****************************************
`define SCS_LANE_SCLK     0
`define SCS_LANE_TXSYNC   1
`define SCS_LANE_RXSYNC   2
`define SCS_LANE_DIN      3
`define SCS_LANES         4

`endif

// File: hw/scs_spi_port.v
`timescale 1ns/10ps
`include "scs_map.vh"

// ****************************************
// Transmit word buffer
// ****************************************
module scs_fifo #(
    parameter W  = 8,
    parameter D  = 4,
    parameter AW = 2
) (
    input  wire         i_clk,
    input  wire         i_rst_n,
    input  wire         i_ce,
    input  wire [W-1:0] i_in_data,
    input  wire         i_in_valid,
    output wire         o_in_ready,
    output wire [W-1:0] o_out_data,
    output wire         o_out_valid,
    input  wire         i_out_ready
);
    localparam [AW:0] FULL = D;
    reg  [W-1:0]  mem_q [0:D-1];
    reg  [AW-1:0] wr_q;
    reg  [AW-1:0] rd_q;
    reg  [AW:0]   cnt_q;
    wire          push;
    wire          pop;

    assign o_in_ready  = (cnt_q != FULL);
    assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
    assign o_out_data  = mem_q[rd_q];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always @(posedge i_clk) begin
        if (i_ce && push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (i_ce) begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // scs_fifo

// ****************************************
// Clock-stop serial port, master or slave
// ****************************************
module scs_spi_port (
    input  wire                    I_MCLK,
    input  wire                    I_RST_N,
    input  wire                    I_CE,
    input  wire                    I_MASTER,
    input  wire [1:0]              I_CLOCK_STOP_MODE,
    input  wire                    I_TX_CLOCK_POLARITY,
    input  wire [`SCS_DIV_W-1:0]   I_SRG_CLOCK_DIVIDER,
    input  wire                    I_TX_SYNC_POLARITY,
    input  wire                    I_RX_SYNC_POLARITY,
    input  wire [`SCS_WORD_W-1:0]  I_TX_DATA,
    input  wire                    I_TX_VALID,
    output wire                    O_TX_READY,
    output wire [`SCS_WORD_W-1:0]  O_RX_DATA,
    output wire                    O_RX_VALID,
    output wire                    O_BUSY,
    output wire                    O_TX_CLOCK_DIRECTION,
    output wire                    O_RX_CLOCK_DIRECTION,
    output wire                    O_TX_SYNC_DIRECTION,
    output wire                    O_RX_SYNC_DIRECTION,
    input  wire                    I_TX_SERIAL_CLOCK_PIN,
    output wire                    O_TX_SERIAL_CLOCK_PIN,
    output wire                    O_TX_SERIAL_CLOCK_PIN_OE_N,
    input  wire                    I_TX_SYNC_PIN,
    output wire                    O_TX_SYNC_PIN,
    output wire                    O_TX_SYNC_PIN_OE_N,
    input  wire                    I_RX_SYNC_PIN,
    output wire                    O_SERIAL_OUT_PIN,
    output wire                    O_SERIAL_OUT_PIN_OE_N,
    input  wire                    I_SERIAL_IN_PIN
);
    reg                       cfg_master_q;
    reg  [1:0]                cfg_mode_q;
    reg                       cfg_pol_q;
    reg  [`SCS_DIV_W-1:0]     cfg_div_q;
    reg                       cfg_txp_q;
    reg                       cfg_rxp_q;
    reg                       tick_q;
    reg  [`SCS_LANES-1:0]     s1_q;
    reg  [`SCS_LANES-1:0]     s2_q;
    reg  [`SCS_LANES-1:0]     s3_q;
    reg  [`SCS_LANES-1:0]     stb_q;
    reg                       sclk_prev_q;
    reg                       s_sel_q;
    reg  [4:0]                st_q;
    reg  [`SCS_CNT_W-1:0]     cnt_q;
    reg  [`SCS_NBIT_W-1:0]    ecnt_q;
    reg                       sclk_q;
    reg                       frame_q;
    reg  [`SCS_WORD_W-1:0]    tsh_q;
    reg  [`SCS_WORD_W-1:0]    rsh_q;
    reg  [`SCS_NBIT_W-1:0]    nbit_q;
    reg                       smp_q;
    reg                       dout_q;
    reg                       drv_q;
    reg  [`SCS_WORD_W-1:0]    rx_data_q;
    reg                       rx_valid_q;
    wire [`SCS_LANES-1:0]     pin_in;
    wire [`SCS_DIV_W-1:0]     divc;
    wire [`SCS_CNT_W-1:0]     div9;
    wire [`SCS_CNT_W-1:0]     half_odd;
    wire [`SCS_CNT_W-1:0]     lo_len;
    wire [`SCS_CNT_W-1:0]     hi_len;
    wire [`SCS_CNT_W-1:0]     per_len;
    wire [`SCS_CNT_W-1:0]     idle_len;
    wire [`SCS_CNT_W-1:0]     act_len;
    wire [`SCS_CNT_W-1:0]     lead_len;
    wire [`SCS_CNT_W-1:0]     trail_len;
    wire                      mode_dly;
    wire                      cfg_ok;
    wire                      st_idle;
    wire                      last_b;
    wire                      s_tx_sel;
    wire                      s_rx_sel;
    wire                      s_chg;
    wire                      m_a;
    wire                      m_b;
    wire                      ev_a;
    wire                      ev_b;
    wire                      samp_ev;
    wire                      launch_ev;
    wire                      rx_act;
    wire                      fifo_valid;
    wire [`SCS_WORD_W-1:0]    fifo_data;
    wire                      m_start;
    wire                      s_start;
    wire                      s_reload;
    wire                      load;
    wire [`SCS_WORD_W-1:0]    load_word;

    // ****************************************
    // Buffer and config
    // ****************************************
    assign load      = m_start | s_start | s_reload;
    assign load_word = fifo_valid ? fifo_data : {`SCS_WORD_W{1'b0}};

    scs_fifo #(
        .W  (`SCS_WORD_W),
        .D  (`SCS_FIFO_DEPTH),
        .AW (`SCS_FIFO_AW)
    ) u_fifo (
        .i_clk       (I_MCLK),
        .i_rst_n     (I_RST_N),
        .i_ce        (I_CE),
        .i_in_data   (I_TX_DATA),
        .i_in_valid  (I_TX_VALID),
        .o_in_ready  (O_TX_READY),
        .o_out_data  (fifo_data),
        .o_out_valid (fifo_valid),
        .i_out_ready (load)
    );

    // Config only changes between transfers
    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            cfg_master_q <= 1'b0;
            cfg_mode_q   <= 2'h0;
            cfg_pol_q    <= 1'b0;
            cfg_div_q    <= `SCS_DIV_MIN;
            cfg_txp_q    <= 1'b0;
            cfg_rxp_q    <= 1'b0;
        end else if (I_CE && st_idle && !s_sel_q && !m_start) begin
            cfg_master_q <= I_MASTER;
            cfg_mode_q   <= I_CLOCK_STOP_MODE;
            cfg_pol_q    <= I_TX_CLOCK_POLARITY;
            cfg_div_q    <= I_SRG_CLOCK_DIVIDER;
            cfg_txp_q    <= I_TX_SYNC_POLARITY;
            cfg_rxp_q    <= I_RX_SYNC_POLARITY;
        end
    end

    assign mode_dly = (cfg_mode_q == `SCS_MODE_DLY);
    assign cfg_ok   = (cfg_mode_q == `SCS_MODE_DLY) || (cfg_mode_q == `SCS_MODE_NODLY);

    // ****************************************
    // Master phase lengths
    // ****************************************
    assign divc      = (cfg_div_q == {`SCS_DIV_W{1'b0}}) ? `SCS_DIV_MIN : cfg_div_q;
    assign div9      = {1'b0, divc};
    assign per_len   = div9 + `SCS_CNT_ONE;
    assign half_odd  = per_len >> 1;
    assign lo_len    = divc[0] ? half_odd : (div9 >> 1);
    assign hi_len    = divc[0] ? half_odd : ((div9 >> 1) + `SCS_CNT_ONE);
    assign idle_len  = cfg_pol_q ? hi_len : lo_len;
    assign act_len   = cfg_pol_q ? lo_len : hi_len;
    assign lead_len  = mode_dly ? per_len : idle_len;
    assign trail_len = mode_dly ? idle_len : per_len;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    assign pin_in = {I_SERIAL_IN_PIN, I_RX_SYNC_PIN, I_TX_SYNC_PIN, I_TX_SERIAL_CLOCK_PIN};

    // Slave lanes except data-in advance on the half-rate sample tick
    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            tick_q <= 1'b0;
        end else if (I_CE) begin
            tick_q <= ~tick_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `SCS_LANES; g = g + 1) begin : g_sync
            localparam [0:0] sel_rst = (g == `SCS_LANE_TXSYNC) || (g == `SCS_LANE_RXSYNC);
            always @(posedge I_MCLK) begin
                if (!I_RST_N) begin
                    s1_q[g]  <= sel_rst;
                    s2_q[g]  <= sel_rst;
                    s3_q[g]  <= sel_rst;
                    stb_q[g] <= sel_rst;
                end else if (I_CE) begin
                    s1_q[g] <= pin_in[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if ((s2_q[g] == s3_q[g]) && (tick_q || (g == `SCS_LANE_DIN))) begin
                        stb_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Slave edge and select decode
    // ****************************************
    assign s_tx_sel = stb_q[`SCS_LANE_TXSYNC] ^ cfg_txp_q;
    assign s_rx_sel = stb_q[`SCS_LANE_RXSYNC] ^ cfg_rxp_q;
    assign s_chg    = stb_q[`SCS_LANE_SCLK] ^ sclk_prev_q;

    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            sclk_prev_q <= 1'b0;
            s_sel_q     <= 1'b0;
        end else if (I_CE) begin
            sclk_prev_q <= stb_q[`SCS_LANE_SCLK];
            s_sel_q     <= s_tx_sel & ~cfg_master_q & cfg_ok;
        end
    end

    // ****************************************
    // Master clock and select sequencer
    // ****************************************
    assign st_idle = (st_q == `SCS_ST_IDLE);
    assign m_start = st_idle & cfg_master_q & cfg_ok & fifo_valid;
    assign last_b  = (ecnt_q == `SCS_BITS_PER_WORD);
    assign m_a     = ((st_q == `SCS_ST_LEAD) && (cnt_q == lead_len)) ||
                     ((st_q == `SCS_ST_INACT) && (cnt_q == idle_len));
    assign m_b     = (st_q == `SCS_ST_ACT) && (cnt_q == act_len);

    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            st_q    <= `SCS_ST_IDLE;
            cnt_q   <= `SCS_CNT_ONE;
            ecnt_q  <= {`SCS_NBIT_W{1'b0}};
            sclk_q  <= 1'b0;
            frame_q <= 1'b0;
        end else if (I_CE) begin
            cnt_q <= cnt_q + `SCS_CNT_ONE;
            case (st_q)
                `SCS_ST_IDLE: begin
                    sclk_q  <= cfg_pol_q;
                    frame_q <= 1'b0;
                    cnt_q   <= `SCS_CNT_ONE;
                    if (m_start) begin
                        st_q    <= `SCS_ST_LEAD;
                        frame_q <= 1'b1;
                        ecnt_q  <= {`SCS_NBIT_W{1'b0}};
                    end
                end
                `SCS_ST_LEAD: begin
                    if (m_a) begin
                        st_q   <= `SCS_ST_ACT;
                        cnt_q  <= `SCS_CNT_ONE;
                        sclk_q <= ~cfg_pol_q;
                        ecnt_q <= ecnt_q + 1'b1;
                    end
                end
                `SCS_ST_ACT: begin
                    if (m_b) begin
                        st_q   <= last_b ? `SCS_ST_TRAIL : `SCS_ST_INACT;
                        cnt_q  <= `SCS_CNT_ONE;
                        sclk_q <= cfg_pol_q;
                    end
                end
                `SCS_ST_INACT: begin
                    if (m_a) begin
                        st_q   <= `SCS_ST_ACT;
                        cnt_q  <= `SCS_CNT_ONE;
                        sclk_q <= ~cfg_pol_q;
                        ecnt_q <= ecnt_q + 1'b1;
                    end
                end
                `SCS_ST_TRAIL: begin
                    if (cnt_q == trail_len) begin
                        st_q    <= `SCS_ST_IDLE;
                        frame_q <= 1'b0;
                    end
                end
                default: begin
                    st_q    <= `SCS_ST_IDLE;
                    frame_q <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Shared shift datapath
    // ****************************************
    assign ev_a      = cfg_master_q ? m_a : (s_chg & (stb_q[`SCS_LANE_SCLK] != cfg_pol_q) & s_tx_sel);
    assign ev_b      = cfg_master_q ? m_b : (s_chg & (stb_q[`SCS_LANE_SCLK] == cfg_pol_q) & s_tx_sel);
    assign samp_ev   = mode_dly ? ev_a : ev_b;
    assign launch_ev = mode_dly ? ev_b : ev_a;
    assign rx_act    = cfg_master_q ? frame_q : s_rx_sel;
    assign s_start   = ~cfg_master_q & cfg_ok & s_tx_sel & ~s_sel_q;
    assign s_reload  = ~cfg_master_q & launch_ev & (nbit_q == `SCS_BITS_PER_WORD);

    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            tsh_q      <= {`SCS_WORD_W{1'b0}};
            rsh_q      <= {`SCS_WORD_W{1'b0}};
            nbit_q     <= {`SCS_NBIT_W{1'b0}};
            smp_q      <= 1'b0;
            dout_q     <= 1'b0;
            drv_q      <= 1'b0;
            rx_data_q  <= {`SCS_WORD_W{1'b0}};
            rx_valid_q <= 1'b0;
        end else if (I_CE) begin
            rx_valid_q <= 1'b0;
            if (load) begin
                tsh_q  <= load_word;
                dout_q <= load_word[`SCS_WORD_W-1];
                nbit_q <= {`SCS_NBIT_W{1'b0}};
                smp_q  <= 1'b0;
            end else begin
                if (samp_ev && rx_act && (nbit_q != `SCS_BITS_PER_WORD)) begin
                    rsh_q  <= {rsh_q[`SCS_WORD_W-2:0], stb_q[`SCS_LANE_DIN]};
                    nbit_q <= nbit_q + 1'b1;
                    smp_q  <= 1'b1;
                    if (nbit_q == (`SCS_BITS_PER_WORD - 1'b1)) begin
                        rx_data_q  <= {rsh_q[`SCS_WORD_W-2:0], stb_q[`SCS_LANE_DIN]};
                        rx_valid_q <= 1'b1;
                    end
                end
                // A launch edge only shifts after a sample, so in no-delay mode the first one of a word is skipped
                if (launch_ev && smp_q) begin
                    tsh_q  <= {tsh_q[`SCS_WORD_W-2:0], 1'b0};
                    dout_q <= tsh_q[`SCS_WORD_W-2];
                    smp_q  <= 1'b0;
                end
            end
            if (!cfg_master_q) begin
                drv_q <= s_tx_sel & cfg_ok;
            end else if (m_start) begin
                drv_q <= 1'b1;
            end else if (mode_dly && m_b && last_b) begin
                drv_q <= 1'b0;
            end else if (!mode_dly && (st_q == `SCS_ST_TRAIL) && (cnt_q == idle_len)) begin
                drv_q <= 1'b0;
            end else if (st_idle) begin
                drv_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign O_RX_DATA                  = rx_data_q;
    assign O_RX_VALID                 = rx_valid_q;
    assign O_BUSY                     = ~st_idle | s_sel_q;
    assign O_TX_CLOCK_DIRECTION       = cfg_master_q;
    assign O_TX_SYNC_DIRECTION        = cfg_master_q;
    assign O_RX_CLOCK_DIRECTION       = 1'b0;
    assign O_RX_SYNC_DIRECTION        = 1'b0;
    assign O_TX_SERIAL_CLOCK_PIN      = sclk_q;
    assign O_TX_SERIAL_CLOCK_PIN_OE_N = ~cfg_master_q;
    assign O_TX_SYNC_PIN              = frame_q ^ cfg_txp_q;
    assign O_TX_SYNC_PIN_OE_N         = ~cfg_master_q;
    assign O_SERIAL_OUT_PIN           = dout_q;
    assign O_SERIAL_OUT_PIN_OE_N      = ~drv_q;
endmodule // scs_spi_port

// File: dv/scs_spi_port_checker.sv
`timescale 1ns/10ps
`include "scs_map.vh"
// ****************************************
// Pin timing checker
// ****************************************
module scs_spi_port_checker (
    input wire                  I_MCLK,
    input wire                  I_RST_N,
    input wire [1:0]            I_CLOCK_STOP_MODE,
    input wire                  I_TX_CLOCK_POLARITY,
    input wire [`SCS_DIV_W-1:0] I_SRG_CLOCK_DIVIDER,
    input wire                  I_TX_SYNC_POLARITY,
    input wire                  I_TX_SYNC_PIN,
    input wire                  O_BUSY,
    input wire                  O_TX_CLOCK_DIRECTION,
    input wire                  O_RX_CLOCK_DIRECTION,
    input wire                  O_TX_SYNC_DIRECTION,
    input wire                  O_RX_SYNC_DIRECTION,
    input wire                  O_TX_SERIAL_CLOCK_PIN,
    input wire                  O_TX_SERIAL_CLOCK_PIN_OE_N,
    input wire                  O_TX_SYNC_PIN,
    input wire                  O_TX_SYNC_PIN_OE_N,
    input wire                  O_SERIAL_OUT_PIN_OE_N
);
    logic [9:0] cnt_q, lo, hi, idl, dv;
    logic       clk_q, sync_q, mid_q;
    wire        drv     = !O_TX_SERIAL_CLOCK_PIN_OE_N;
    wire        clk_chg = O_TX_SERIAL_CLOCK_PIN != clk_q;
    wire        rel     = drv && mid_q && (O_TX_SYNC_PIN != sync_q);
    assign dv  = (I_SRG_CLOCK_DIVIDER == 0) ? 10'h001 : {2'h0, I_SRG_CLOCK_DIVIDER};
    assign lo  = dv[0] ? ((dv + 10'h001) >> 1) : (dv >> 1);
    assign hi  = dv[0] ? lo : lo + 10'h001;
    assign idl = I_TX_CLOCK_POLARITY ? hi : lo;

    // Cycles since last clock or select change
    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            cnt_q  <= 10'h000;
            clk_q  <= 1'b0;
            sync_q <= 1'b0;
            mid_q  <= 1'b0;
        end else begin
            cnt_q  <= (clk_chg || O_TX_SYNC_PIN != sync_q) ? 10'h001 : cnt_q + 10'h001;
            clk_q  <= O_TX_SERIAL_CLOCK_PIN;
            sync_q <= O_TX_SYNC_PIN;
            mid_q  <= rel ? 1'b0 : (mid_q || (clk_chg && drv && O_BUSY));
        end
    end

    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);

    sel_active_a: assert property (clk_chg && drv && O_BUSY |-> O_TX_SYNC_PIN == !I_TX_SYNC_POLARITY)
        else $error("clock edge outside select");
    dir_master_a: assert property (drv |-> O_TX_CLOCK_DIRECTION && O_TX_SYNC_DIRECTION && !O_TX_SYNC_PIN_OE_N)
        else $error("master directions wrong");
    dir_rx_a: assert property (!O_RX_CLOCK_DIRECTION && !O_RX_SYNC_DIRECTION)
        else $error("receive side not external");
    dir_slave_a: assert property (!O_TX_CLOCK_DIRECTION |-> O_TX_SERIAL_CLOCK_PIN_OE_N && O_TX_SYNC_PIN_OE_N)
        else $error("slave drives clock or sync");
    idle_clk_a: assert property (drv && $past(drv) && !O_BUSY && !$past(O_BUSY)
        |-> O_TX_SERIAL_CLOCK_PIN == I_TX_CLOCK_POLARITY) else $error("idle clock level wrong");
    phase_len_a: assert property (clk_chg && drv && mid_q |-> cnt_q == (clk_q ? hi : lo))
        else $error("clock phase length wrong");
    lead_a: assert property (clk_chg && drv && O_BUSY && !mid_q
        |-> cnt_q == ((I_CLOCK_STOP_MODE == `SCS_MODE_DLY) ? lo + hi : idl)) else $error("select lead wrong");
    trail_a: assert property (rel |-> cnt_q == ((I_CLOCK_STOP_MODE == `SCS_MODE_DLY) ? idl : lo + hi))
        else $error("select trail wrong");
    dout_rel_a: assert property ($rose(O_SERIAL_OUT_PIN_OE_N) && drv && I_CLOCK_STOP_MODE == `SCS_MODE_NODLY
        |-> cnt_q == idl) else $error("data release time wrong");
    slave_rel_a: assert property ($rose(I_TX_SYNC_PIN) && !O_TX_SYNC_DIRECTION && I_TX_SYNC_POLARITY
        |-> ##[0:8] O_SERIAL_OUT_PIN_OE_N) else $error("slave data not released");
endmodule // scs_spi_port_checker

// File: dv/scs_peer_slave.sv
`timescale 1ns/10ps
// ****************************************
// Far-side serial slave
// ****************************************
module scs_peer_slave (
    input  wire       i_sclk,
    input  wire       i_sel_n,
    input  wire       i_mosi,
    input  wire [1:0] i_mode,
    input  wire       i_pol,
    input  wire [7:0] i_word,
    output reg        o_miso,
    output reg  [7:0] o_word,
    output reg  [7:0] o_count
);
    reg  [7:0] sh_q;
    reg  [3:0] n_q;
    wire       samp_rise = (i_mode == 2'h3) ^ i_pol;
    initial begin
        o_miso  = 1'b0;
        o_word  = 8'h00;
        o_count = 8'h00;
        sh_q    = 8'h00;
        n_q     = 4'h0;
    end
    always @(negedge i_sel_n) begin
        sh_q   = i_word;
        n_q    = 4'h0;
        o_miso = i_word[7];
    end
    // Released line must not keep the last bit
    always @(posedge i_sel_n) o_miso = ~o_miso;
    always @(i_sclk) begin
        if (!i_sel_n && i_sclk == samp_rise) begin
            o_word = {o_word[6:0], i_mosi};
            n_q    = n_q + 4'h1;
            if (n_q == 4'h8)
                o_count = o_count + 8'h01;
        end else if (!i_sel_n && n_q != 4'h0 && n_q < 4'h8) begin
            sh_q   = sh_q << 1;
            o_miso = sh_q[7];
        end
    end
endmodule // scs_peer_slave

// File: dv/test_scs_spi_port.sv
`timescale 1ns/10ps
`include "scs_map.vh"
module test_scs_spi_port;
    reg         mclk = 0, rst_n = 0, master = 0, pol = 0, txv = 0, ext_clk = 0, ext_sel = 1, ext_din = 0;
    reg  [1:0]  mode = 2'h0;
    reg  [7:0]  div = 8'h07, txd = 8'h00, peer_tx = 8'h00, rx_got = 8'h00;
    integer     error_cnt = 0, num_checks = 0, rx_n = 0;
    wire [7:0]  rx_data, peer_rx, peer_cnt;
    wire        tx_rdy, rx_vld, busy, ck_o, ck_oe_n, sy_o, sy_oe_n, do_o, do_oe_n, miso;
    wire        ck_w = ck_oe_n ? ext_clk : ck_o;
    wire        sy_w = sy_oe_n ? ext_sel : sy_o;
    wire        di_w = master ? miso : ext_din;
    always #10 mclk = ~mclk;

    scs_spi_port DUT (
        .I_MCLK(mclk), .I_RST_N(rst_n), .I_CE(1'b1), .I_MASTER(master), .I_CLOCK_STOP_MODE(mode),
        .I_TX_CLOCK_POLARITY(pol), .I_SRG_CLOCK_DIVIDER(div), .I_TX_SYNC_POLARITY(1'b1),
        .I_RX_SYNC_POLARITY(1'b1), .I_TX_DATA(txd), .I_TX_VALID(txv), .O_TX_READY(tx_rdy),
        .O_RX_DATA(rx_data), .O_RX_VALID(rx_vld), .O_BUSY(busy), .O_TX_CLOCK_DIRECTION(),
        .O_RX_CLOCK_DIRECTION(), .O_TX_SYNC_DIRECTION(), .O_RX_SYNC_DIRECTION(),
        .I_TX_SERIAL_CLOCK_PIN(ck_w), .O_TX_SERIAL_CLOCK_PIN(ck_o), .O_TX_SERIAL_CLOCK_PIN_OE_N(ck_oe_n),
        .I_TX_SYNC_PIN(sy_w), .O_TX_SYNC_PIN(sy_o), .O_TX_SYNC_PIN_OE_N(sy_oe_n), .I_RX_SYNC_PIN(sy_w),
        .O_SERIAL_OUT_PIN(do_o), .O_SERIAL_OUT_PIN_OE_N(do_oe_n), .I_SERIAL_IN_PIN(di_w));

    scs_peer_slave u_peer (.i_sclk(ck_w), .i_sel_n(sy_w), .i_mosi(do_o), .i_mode(mode), .i_pol(pol),
        .i_word(peer_tx), .o_miso(miso), .o_word(peer_rx), .o_count(peer_cnt));

    always @(posedge mclk)
        if (rx_vld === 1'b1) begin
            rx_got <= rx_data;
            rx_n   <= rx_n + 1;
        end

    task check(input [7:0] got, input [7:0] exp, input [8*12-1:0] msg);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("mismatch at %0t: %0s got %h exp %h", $time, msg, got, exp);
            end
        end
    endtask

    task wrap_up;
        begin
            if (error_cnt == 0 && num_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    task setup(input m, input [1:0] md, input p, input [7:0] d);
        begin
            rst_n   <= 1'b0;
            master  <= m;
            mode    <= md;
            pol     <= p;
            div     <= d;
            ext_clk <= p;
            ext_sel <= 1'b1;
            repeat (8) @(posedge mclk);
            rst_n <= 1'b1;
            @(posedge mclk);
        end
    endtask

    // Caller lowers valid after the last word
    task push(input [7:0] w);
        begin
            txd <= w;
            txv <= 1'b1;
            @(posedge mclk);
            while (tx_rdy !== 1'b1)
                @(posedge mclk);
        end
    endtask

    task wait_idle;
        integer i;
        begin
            repeat (3) @(posedge mclk);
            for (i = 0; i < 3000 && busy !== 1'b0; i = i + 1)
                @(posedge mclk);
            repeat (4) @(posedge mclk);
        end
    endtask

    task master_xfer(input [1:0] md, input p, input [7:0] d, input [7:0] w);
        integer n0;
        begin
            setup(1'b1, md, p, d);
            peer_tx <= ~w;
            n0 = rx_n;
            push(w);
            txv <= 1'b0;
            wait_idle;
            check(peer_rx, w, "peer rx");
            check(rx_got, ~w, "master rx");
            check(8'(rx_n - n0), 8'h01, "rx count");
            check({7'h0, ck_w}, {7'h0, p}, "idle clock");
            check({7'h0, sy_w}, 8'h01, "select off");
        end
    endtask

    task fifo_fill;
        integer i;
        reg [7:0] c0;
        begin
            setup(1'b1, 2'h0, 1'b0, 8'h08);
            c0 = peer_cnt;
            for (i = 0; i < 4; i = i + 1)
                push(8'h10 + i[7:0]);
            txd <= 8'hee;
            @(posedge mclk);
            check({7'h0, tx_rdy}, 8'h00, "fifo full");
            txv  <= 1'b0;
            mode <= 2'h2;
            for (i = 0; i < 3000 && peer_cnt != c0 + 8'h04; i = i + 1)
                @(posedge mclk);
            wait_idle;
            repeat (200) @(posedge mclk);
            check(peer_cnt - c0, 8'h04, "words sent");
            check(peer_rx, 8'h13, "last word");
        end
    endtask

    task slave_xfer(input [1:0] md, input p, input [7:0] a, input [7:0] b);
        integer k, n;
        reg [7:0] got;
        begin
            setup(1'b0, md, p, 8'h01);
            n   = 0;
            got = 8'h00;
            push(a);
            txv <= 1'b0;
            repeat (4) @(posedge mclk);
            ext_sel <= 1'b0;
            ext_din <= b[7];
            repeat (8) @(posedge mclk);
            for (k = 0; k < 16; k = k + 1) begin
                ext_clk <= ~ext_clk;
                if (ext_clk == (md == 2'h2 && !p)) begin
                    got = {got[6:0], do_o};
                    n   = n + 1;
                end else if (n > 0 && n < 8)
                    ext_din <= b[7 - n];
                repeat (8) @(posedge mclk);
            end
            ext_sel <= 1'b1;
            ext_din <= ~ext_din;
            repeat (10) @(posedge mclk);
            check(got, a, "slave tx");
            check(rx_got, b, "slave rx");
            check({7'h0, do_oe_n}, 8'h01, "dout release");
        end
    endtask

    initial begin
        @(posedge mclk);
        // Dividers leave time for input sync
        master_xfer(2'h2, 1'b0, 8'h0a, 8'ha5);
        master_xfer(2'h3, 1'b0, 8'h0c, 8'h3c);
        master_xfer(2'h2, 1'b1, 8'h09, 8'hc3);
        master_xfer(2'h3, 1'b1, 8'h0a, 8'h96);
        fifo_fill;
        slave_xfer(2'h2, 1'b0, 8'h5a, 8'h81);
        slave_xfer(2'h3, 1'b0, 8'h7e, 8'h18);
        slave_xfer(2'h2, 1'b1, 8'hc6, 8'h39);
        wrap_up;
    end

    initial begin
        #400000;
        error_cnt = error_cnt + 1;
        wrap_up;
    end
endmodule // test_scs_spi_port

bind scs_spi_port scs_spi_port_checker u_chk (
    .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_CLOCK_STOP_MODE(I_CLOCK_STOP_MODE),
    .I_TX_CLOCK_POLARITY(I_TX_CLOCK_POLARITY), .I_SRG_CLOCK_DIVIDER(I_SRG_CLOCK_DIVIDER),
    .I_TX_SYNC_POLARITY(I_TX_SYNC_POLARITY), .I_TX_SYNC_PIN(I_TX_SYNC_PIN), .O_BUSY(O_BUSY),
    .O_TX_CLOCK_DIRECTION(O_TX_CLOCK_DIRECTION), .O_RX_CLOCK_DIRECTION(O_RX_CLOCK_DIRECTION),
    .O_TX_SYNC_DIRECTION(O_TX_SYNC_DIRECTION), .O_RX_SYNC_DIRECTION(O_RX_SYNC_DIRECTION),
    .O_TX_SERIAL_CLOCK_PIN(O_TX_SERIAL_CLOCK_PIN), .O_TX_SERIAL_CLOCK_PIN_OE_N(O_TX_SERIAL_CLOCK_PIN_OE_N),
    .O_TX_SYNC_PIN(O_TX_SYNC_PIN), .O_TX_SYNC_PIN_OE_N(O_TX_SYNC_PIN_OE_N),
    .O_SERIAL_OUT_PIN_OE_N(O_SERIAL_OUT_PIN_OE_N));
